/* File: sls_host.sv */
// Purpose: host model driving select, link clock and serial data
// Assumes: 6 ns link clock, made inside a select window except by idle_pulses
// Notes:   released data line flips so no stale bit looks valid
`timescale 1ns/1ps

module sls_host (
  output logic link_clk,
  output logic load_window_select_n,
  output logic sdi
);
  initial begin
    link_clk             = 1'b1;
    load_window_select_n = 1'b1;
    sdi                  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one window, msb first; clock high at both ends of the train
  task automatic send(input logic [31:0] word, input int nbits);
    load_window_select_n = 1'b0;
    #7;
    for (int i = nbits - 1; i >= 0; i--) begin
      link_clk = 1'b0;
      sdi      = word[i];
      #3;
      link_clk = 1'b1;
      #3;
    end
    #7;
    load_window_select_n = 1'b1;
    sdi = ~sdi;
  endtask : send

  // stray clocks with select high, to be ignored by the device
  task automatic idle_pulses(input int n);
    sdi = 1'b1;
    repeat (n) begin
      link_clk = 1'b0;
      #3;
      link_clk = 1'b1;
      #3;
    end
  endtask : idle_pulses
endmodule : sls_host

/* File: sls_pkg.sv */
// Purpose: shared constants and state carriers for the serial led segment latch
// Assumes: one system clock (mclk) and one serial link clock from the host
// Notes:   widths here are defaults; the top module may override the word width
package sls_pkg;

  // word width of one serial transfer, one bit per segment buffer
  localparam int unsigned SEG_W        = 16;

  // values after reset
  localparam logic [SEG_W-1:0] SEG_RST = 16'h0000;
  localparam logic             SEL_RST = 1'b1;   // select idles high (inactive)
  localparam logic             LT_RST  = 1'b1;   // lamp test idles high (normal)

  // cycles from a select rise at the pin to a new segment pattern
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned LOAD_LAT     = SYNC_STAGES + 2;

  // link-side state: shift chain and serial output stage
  typedef struct packed {
    logic [SEG_W-1:0] shreg;
    logic             sdo;
  } sls_link_t;

  // system-side state: synchronisers, latches and the output register
  typedef struct packed {
    logic             sel_s1;
    logic             sel_s2;
    logic             sel_s3;
    logic             lt_s1;
    logic             lt_s2;
    logic [SEG_W-1:0] latch;
    logic [SEG_W-1:0] seg;
  } sls_sys_t;

endpackage : sls_pkg

/* File: sls_top.sv */
// Purpose: serial-in parallel-out latch driving sixteen led segment buffers
// Assumes: link_clk may also toggle outside a select window; mclk runs free at 200 MHz
// Notes:   the shift chain stands still while select is high, so the system side
//          may copy it after the synchronised select rise without a handshake
//          limitation: a host that opens the next window and clocks while a copy is due
//          can tear the word, since the copy trusts the chain to be quiet
//          lamp test and select both pass two flip-flops on mclk before use
//          the word-position check below is written for the default width
//
// Notes on behaviour
// - A 16-bit serial word enters through select, clock and data into a shift chain.
// - Select is active low and the device only shifts while it is held low.
// - When select falls the latches stop following so outputs keep their old state.
// - When select rises the latches take the shifted pattern onto the segment outputs.
// - Each rising link clock edge inside a window samples data, shifts the chain and updates the serial data output.
// - The last stage of the chain is driven on the serial data output for cascading.
// - A latched one switches its segment buffer on and a latched zero leaves it off.
// - A low lamp-test input forces every segment buffer on whatever is latched.
`timescale 1ns/1ps

module sls_top #(
  parameter int unsigned SEG_W = sls_pkg::SEG_W
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             link_clk,
  input  wire logic             load_window_select_n,
  input  wire logic             sdi,
  input  wire logic             lamp_test_n,
  output logic                  sdo,
  output logic [SEG_W-1:0]      seg_on
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check: the chain needs at least two stages to shift through

  if (SEG_W < 2 || SEG_W > 64) begin : g_bad_width
    $error("sls_top: SEG_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release synchroniser, the rest of the design uses rst_sync_n

  logic rst_m1_q;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m1_q   <= 1'b1;
      rst_sync_n <= rst_m1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shift chain clocked by the host's serial clock

  logic [SEG_W-1:0] shreg_q;
  logic [SEG_W-1:0] shreg_d;
  logic             sdo_q;
  logic             sdo_d;

  // next chain value for one shift; shared by the logic and its check
  function automatic logic [SEG_W-1:0] sls_shift(
    input logic [SEG_W-1:0] chain,
    input logic             bit_in
  );
    return {chain[SEG_W-2:0], bit_in};
  endfunction : sls_shift

  // select and data are launched by the host against link_clk, so no sync
  always_comb begin
    shreg_d = shreg_q;
    sdo_d   = sdo_q;
    if (!load_window_select_n) begin
      shreg_d = sls_shift(shreg_q, sdi);
      sdo_d   = shreg_q[SEG_W-2];
    end
  end

  // reset release here is safe: with select high a link_clk edge leaves the chain and sdo_q unchanged
  always_ff @(posedge link_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      shreg_q <= '0;
      sdo_q   <= 1'b0;
    end else begin
      shreg_q <= shreg_d;
      sdo_q   <= sdo_d;
    end
  end

  // chaining relies on the next part sampling on the edge after ours
  assign sdo = sdo_q;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: one struct holds every flip-flop on mclk except the reset synchroniser

  typedef struct packed {
    logic             sel_s1;
    logic             sel_s2;
    logic             sel_s3;
    logic             lt_s1;
    logic             lt_s2;
    logic [SEG_W-1:0] latch;
    logic [SEG_W-1:0] seg;
  } sls_state_t;

  sls_state_t q;
  sls_state_t d;
  logic       sel_rise;

  // the copy happens only once select is back high, when the chain is quiet
  assign sel_rise = q.sel_s2 & ~q.sel_s3;

  always_comb begin
    d        = q;
    d.sel_s1 = load_window_select_n;
    d.sel_s2 = q.sel_s1;
    d.sel_s3 = q.sel_s2;
    d.lt_s1  = lamp_test_n;
    d.lt_s2  = q.lt_s1;
    // latches are frozen for the whole window, updated only on the rise
    if (sel_rise) begin
      d.latch = shreg_q;
    end
    // lamp test overrides the pattern, otherwise a one lights its buffer
    if (!q.lt_s2) begin
      d.seg = '1;
    end else begin
      d.seg = q.latch;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q.sel_s1 <= sls_pkg::SEL_RST;
      q.sel_s2 <= sls_pkg::SEL_RST;
      q.sel_s3 <= sls_pkg::SEL_RST;
      q.lt_s1  <= sls_pkg::LT_RST;
      q.lt_s2  <= sls_pkg::LT_RST;
      q.latch  <= '0;
      q.seg    <= '0;
    end else begin
      q <= d;
    end
  end

  assign seg_on = q.seg;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the link side

  // every clock inside a window moves the chain by exactly one place
  property p_shift_in;
    @(posedge link_clk) disable iff (!rst_sync_n)
    !load_window_select_n |=> shreg_q == sls_shift($past(shreg_q), $past(sdi));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("chain did not shift");

  property p_idle_hold;
    @(posedge link_clk) disable iff (!rst_sync_n)
    load_window_select_n |=> $stable(shreg_q) && $stable(sdo_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("chain moved outside window");

  property p_sdo_last;
    @(posedge link_clk) disable iff (!rst_sync_n)
    !load_window_select_n |=> sdo_q == shreg_q[SEG_W-1];
  endproperty
  a_sdo_last: assert property (p_sdo_last) else $error("serial out not last stage");

  // a one taken in, then fifteen more shifts, must sit in the top stage
  property p_word_bits;
    @(posedge link_clk) disable iff (!rst_sync_n)
    (!load_window_select_n && sdi) ##1 (!load_window_select_n)[*8]
      ##1 (!load_window_select_n)[*7] |=> shreg_q[SEG_W-1];
  endproperty
  a_word_bits: assert property (p_word_bits) else $error("first bit not at top");

  // serial out takes the stage below the top on each shift
  property p_sdo_next;
    @(posedge link_clk) disable iff (!rst_sync_n)
    !load_window_select_n |=> sdo_q == $past(shreg_q[SEG_W-2]);
  endproperty
  a_sdo_next: assert property (p_sdo_next) else $error("serial out not shifted");

  // link side is cleared while reset stands, no link clock needed
  property p_sdo_reset;
    @(posedge mclk)
    !rst_sync_n |-> !sdo_q && shreg_q == '0;
  endproperty
  a_sdo_reset: assert property (p_sdo_reset) else $error("chain not cleared");

  ////////////////////////////////////////////////////////////////////////////
  // checks on the system side

  sequence s_sel_rise;
    q.sel_s2 && !q.sel_s3;
  endsequence

  sequence s_copied;
    ##1 q.latch == $past(shreg_q);
  endsequence

  property p_load;
    @(posedge mclk) disable iff (!rst_sync_n)
    s_sel_rise |-> s_copied;
  endproperty
  a_load: assert property (p_load) else $error("latch missed shifted word");

  property p_window_hold;
    @(posedge mclk) disable iff (!rst_sync_n)
    !q.sel_s2 |=> $stable(q.latch);
  endproperty
  a_window_hold: assert property (p_window_hold) else $error("latch moved in window");

  property p_pattern;
    @(posedge mclk) disable iff (!rst_sync_n)
    q.lt_s2 |=> seg_on == $past(q.latch);
  endproperty
  a_pattern: assert property (p_pattern) else $error("segments differ from latch");

  property p_lamp_test;
    @(posedge mclk) disable iff (!rst_sync_n)
    !lamp_test_n ##1 !lamp_test_n ##1 !lamp_test_n |=> &seg_on;
  endproperty
  a_lamp_test: assert property (p_lamp_test) else $error("lamp test not all on");

  property p_rise_to_seg;
    @(posedge mclk) disable iff (!rst_sync_n)
    (s_sel_rise ##0 q.lt_s2) ##1 q.lt_s2 |=> seg_on == $past(shreg_q, 2);
  endproperty
  a_rise_to_seg: assert property (p_rise_to_seg) else $error("new word not shown");

  // the latch only ever moves on the detected rise
  property p_latch_quiet;
    @(posedge mclk) disable iff (!rst_sync_n)
    !(q.sel_s2 && !q.sel_s3) |=> $stable(q.latch);
  endproperty
  a_latch_quiet: assert property (p_latch_quiet) else $error("latch moved off a rise");

  // the chain must already be quiet when the system side copies it
  property p_chain_quiet;
    @(posedge mclk) disable iff (!rst_sync_n)
    s_sel_rise |-> $stable(shreg_q);
  endproperty
  a_chain_quiet: assert property (p_chain_quiet) else $error("chain moving at copy");

  // synchronised lamp test low lights everything on the next edge
  property p_lamp_now;
    @(posedge mclk) disable iff (!rst_sync_n)
    !q.lt_s2 |=> &seg_on;
  endproperty
  a_lamp_now: assert property (p_lamp_now) else $error("lamp test slow");

  // after lamp test is released the latched pattern comes back
  property p_lamp_exit;
    @(posedge mclk) disable iff (!rst_sync_n)
    lamp_test_n[*3] |=> seg_on == $past(q.latch);
  endproperty
  a_lamp_exit: assert property (p_lamp_exit) else $error("pattern not restored");

  // an all-zero latch leaves every buffer off
  property p_seg_zero;
    @(posedge mclk) disable iff (!rst_sync_n)
    q.lt_s2 && q.latch == '0 |=> seg_on == '0;
  endproperty
  a_seg_zero: assert property (p_seg_zero) else $error("buffer on for a zero");

  // reset leaves every buffer dark and the latch empty
  property p_reset_clear;
    @(posedge mclk)
    !rst_sync_n |-> seg_on == '0 && q.latch == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs lit in reset");

  // pin rise to new pattern: two sync flops, edge detect, latch, output
  sequence s_pin_rise;
    $rose(load_window_select_n);
  endsequence

  property p_pin_to_seg;
    @(posedge mclk) disable iff (!rst_sync_n)
    s_pin_rise ##0 q.lt_s2[*5] |-> seg_on == shreg_q;
  endproperty
  a_pin_to_seg: assert property (p_pin_to_seg) else $error("word late at outputs");

  // one check per buffer, so a failure names the segment that went wrong
  for (genvar gi = 0; gi < SEG_W; gi++) begin : g_seg_chk
    property p_seg_bit;
      @(posedge mclk) disable iff (!rst_sync_n)
      q.lt_s2 |=> seg_on[gi] == $past(q.latch[gi]);
    endproperty
    a_seg_bit: assert property (p_seg_bit) else $error("segment off its latch");
  end

endmodule : sls_top

/* File: tb.sv */
// Purpose: self-checking bench for the segment latch
// Assumes: host model clocks only inside windows, apart from the idle_pulses step
// Notes:   settle waits cover the select synchroniser latency
`timescale 1ns/1ps

module tb;
  logic        mclk;
  logic        rst_n;
  logic        lamp_test_n;
  logic        link_clk;
  logic        load_window_select_n;
  logic        sdi;
  logic        sdo;
  logic [15:0] seg_on;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  sls_top dut_u (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
    .load_window_select_n(load_window_select_n), .sdi(sdi),
    .lamp_test_n(lamp_test_n), .sdo(sdo), .seg_on(seg_on));
  sls_host host_u (.link_clk(link_clk), .load_window_select_n(load_window_select_n),
    .sdi(sdi));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // one window, then wait out the load latency
  task automatic load(input logic [31:0] word, input int nbits);
    @(negedge mclk);
    host_u.send(word, nbits);
    repeat (sls_pkg::LOAD_LAT + 4) @(negedge mclk);
  endtask : load

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_hold();
    @(negedge mclk);
    fork
      host_u.send(32'h0000003c, 8);
      begin
        #40;
        chk(seg_on, 16'ha5c3);
      end
    join
    repeat (sls_pkg::LOAD_LAT + 4) @(negedge mclk);
    chk(seg_on, 16'hc33c);
  endtask : t_hold

  task automatic t_lamp();
    lamp_test_n = 1'b0;
    repeat (6) @(negedge mclk);
    chk(seg_on, 16'hffff);
    lamp_test_n = 1'b1;
    repeat (6) @(negedge mclk);
    chk(seg_on, 16'h2345);
  endtask : t_lamp

  initial begin
    rst_n       = 1'b0;
    lamp_test_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk(seg_on, 16'h0000);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    load(32'h0000a5c3, 16);
    chk(seg_on, 16'ha5c3);
    chk({15'h0000, sdo}, 16'h0001);
    t_hold();
    // overlong word: only the last sixteen bits stay
    load(32'h00012345, 20);
    chk(seg_on, 16'h2345);
    chk({15'h0000, sdo}, 16'h0000);
    // clocks with select high must not move the chain
    @(negedge mclk);
    host_u.idle_pulses(4);
    load(32'h00000000, 0);
    chk(seg_on, 16'h2345);
    t_lamp();
    tally_and_finish();
  end
endmodule : tb
